//--- src/csth_pkg.sv
package csth_pkg;

   // open-drain drive encoding
   typedef enum logic [1:0] {
      CSTH_OD_HIZ    = 2'b00,
      CSTH_OD_STRONG = 2'b01,
      CSTH_OD_WEAK   = 2'b10
   } csth_od_t;

   // comparator flags, already synchronous
   typedef struct packed {
      logic supply_ok;      // above lockout_threshold
      logic bat_low;        // below trickle threshold
      logic tenth_current;  // current at a tenth of full scale
      logic therm_hot;
      logic therm_cold;
      logic therm_grounded; // thermistor_input tied to ground
      logic current_program_pin_shutdown;  // current_program_pin above shutdown threshold
   } csth_cmp_t;

   typedef struct packed {
      csth_od_t power_present_flag;
      csth_od_t charge_status_pin;
      csth_od_t fault_pin;
   } csth_status_t;

   localparam int CSTH_TIMER_W       = 24;
   localparam int CSTH_TIMER_TERM    = 24'hFFFFFF;
   localparam int CSTH_QUARTER_SHIFT = 2;
   localparam logic [CSTH_TIMER_W-1:0] CSTH_TIMER_RST = 24'h000000;

endpackage

//--- src/csth_timer.sv
`timescale 1ns/100ps
`default_nettype none
// charge timer: advances on tick while running, clears on restart
module csth_timer #(
   parameter int TIMER_W = csth_pkg::CSTH_TIMER_W
) (
   input  wire logic               ref_clk,
   input  wire logic               srst,
   input  wire logic               clear,
   input  wire logic               run,
   input  wire logic               tick,
   input  wire logic [TIMER_W-1:0] term,
   output logic      [TIMER_W-1:0] count,
   output logic                    quarter,
   output logic                    expired
);
   logic [TIMER_W-1:0] cnt_q;
   logic [TIMER_W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (clear) begin
         cnt_d = TIMER_W'(csth_pkg::CSTH_TIMER_RST);
      end else if (run && tick && (cnt_q != term)) begin
         cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_q <= TIMER_W'(csth_pkg::CSTH_TIMER_RST);
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign count   = cnt_q;
   assign quarter = (cnt_q >= (term >> csth_pkg::CSTH_QUARTER_SHIFT));
   assign expired = (cnt_q == term);
endmodule
`default_nettype wire

//--- src/csth_status.sv
// How it works
// - power indicator strong low while supply is above lockout, else released
// - charging before tenth point, no hold: fault high, status strong low
// - hold before tenth point: pause current and timer, fault low, status strong
// - after tenth point, normal: fault high, status weak pulldown
// - hold after tenth point: pause, fault low, status weak pulldown
// - normal timer expiry ends charge, fault and status both released
// - low battery for quarter time: release status and assert fault together
// - after normal timeout a later temperature fault lowers fault afterwards
// - cycle start pulls status pin down with the strong transistor
// - tenth current latches strong pulldown off, weak pulldown on
// - timer expiry puts status pin in high impedance
// - hot comparator enters temperature hold
// - cold comparator enters temperature hold
// - hold freezes timer and stops charge until temperature valid
// - grounded thermistor input disables temperature hold
// - tenth latch clears on shutdown pin or supply toggle
// - bad-cell fault clears on supply toggle, shutdown, or battery above threshold
// - shutdown turns charger off and resets timer
// - start below trickle threshold charges at a tenth current
`timescale 1ns/100ps
`default_nettype none
module csth_status #(
   parameter int TIMER_W = csth_pkg::CSTH_TIMER_W
) (
   input  wire logic                   ref_clk,
   input  wire logic                   srst,
   input  wire csth_pkg::csth_cmp_t    cmp_in,
   input  wire logic                   timer_tick,
   input  wire logic [TIMER_W-1:0]     timer_term,
   output csth_pkg::csth_status_t      status_out,
   output logic                        power_present_flag_oe,
   output logic                        charge_status_pin_oe,
   output logic                        fault_pin_oe,
   output logic                        power_present_flag_o,
   output logic                        charge_status_pin_o,
   output logic                        fault_pin_o,
   output logic                        charge_enable,
   output logic                        trickle_mode,
   output logic                        temp_hold
);
   typedef enum logic [1:0] {
      CSTH_IDLE    = 2'b00,
      CSTH_CHARGE  = 2'b01,
      CSTH_DONE    = 2'b10,
      CSTH_BADCELL = 2'b11
   } csth_state_t;

   csth_state_t  st_q, st_d;
   logic         tenth_q, tenth_d;
   logic         trickle_q, trickle_d;
   logic         active;
   logic         hold;
   logic         quarter;
   logic         expired;
   logic         restart;
   logic [TIMER_W-1:0] cnt;
   csth_pkg::csth_status_t st_out_d, st_out_q;

   assign active  = cmp_in.supply_ok && !cmp_in.current_program_pin_shutdown;
   assign restart = !active; // supply toggle or shutdown
   assign hold    = !cmp_in.therm_grounded && (cmp_in.therm_hot || cmp_in.therm_cold);

   csth_timer #(
      .TIMER_W (TIMER_W)
   ) u_timer (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clear   (restart || (st_q == CSTH_IDLE)),
      .run     ((st_q == CSTH_CHARGE) && !hold),
      .tick    (timer_tick),
      .term    (timer_term),
      .count   (cnt),
      .quarter (quarter),
      .expired (expired)
   );

   always_comb begin
      st_d      = st_q;
      tenth_d   = tenth_q;
      trickle_d = trickle_q;
      case (st_q)
         CSTH_IDLE: begin
            tenth_d = 1'b0;
            if (active) begin
               st_d      = CSTH_CHARGE;
               trickle_d = cmp_in.bat_low;
            end
         end
         CSTH_CHARGE: begin
            if (!cmp_in.bat_low) begin
               trickle_d = 1'b0;
            end
            if (cmp_in.tenth_current && !trickle_q && !hold) begin
               tenth_d = 1'b1;
            end
            if (trickle_q && cmp_in.bat_low && quarter) begin
               st_d = CSTH_BADCELL;
            end else if (expired) begin
               st_d = CSTH_DONE;
            end
         end
         CSTH_DONE: begin
            st_d = CSTH_DONE;
         end
         CSTH_BADCELL: begin
            if (!cmp_in.bat_low) begin
               st_d = CSTH_IDLE;
            end
         end
         default: begin
            st_d = CSTH_IDLE;
         end
      endcase
      if (restart) begin
         st_d      = CSTH_IDLE;
         tenth_d   = 1'b0;
         trickle_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q      <= CSTH_IDLE;
         tenth_q   <= 1'b0;
         trickle_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         tenth_q   <= tenth_d;
         trickle_q <= trickle_d;
      end
   end

   // output encoding from next state so bad-cell release and fault coincide
   always_comb begin
      st_out_d.power_present_flag = cmp_in.supply_ok ? csth_pkg::CSTH_OD_STRONG
                                                     : csth_pkg::CSTH_OD_HIZ;
      st_out_d.charge_status_pin  = csth_pkg::CSTH_OD_HIZ;
      st_out_d.fault_pin          = csth_pkg::CSTH_OD_HIZ;
      case (st_d)
         CSTH_CHARGE: begin
            st_out_d.charge_status_pin = tenth_d ? csth_pkg::CSTH_OD_WEAK
                                                 : csth_pkg::CSTH_OD_STRONG;
            st_out_d.fault_pin = hold ? csth_pkg::CSTH_OD_STRONG
                                      : csth_pkg::CSTH_OD_HIZ;
         end
         CSTH_DONE: begin
            st_out_d.fault_pin = hold ? csth_pkg::CSTH_OD_STRONG
                                      : csth_pkg::CSTH_OD_HIZ;
         end
         CSTH_BADCELL: begin
            st_out_d.fault_pin = csth_pkg::CSTH_OD_STRONG;
         end
         default: begin
            st_out_d.charge_status_pin = csth_pkg::CSTH_OD_HIZ;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_out_q <= '{csth_pkg::CSTH_OD_HIZ, csth_pkg::CSTH_OD_HIZ, csth_pkg::CSTH_OD_HIZ};
      end else begin
         st_out_q <= st_out_d;
      end
   end

   assign status_out            = st_out_q;
   assign power_present_flag_oe = (st_out_q.power_present_flag == csth_pkg::CSTH_OD_STRONG);
   assign charge_status_pin_oe  = (st_out_q.charge_status_pin == csth_pkg::CSTH_OD_STRONG);
   assign fault_pin_oe          = (st_out_q.fault_pin == csth_pkg::CSTH_OD_STRONG);
   assign power_present_flag_o  = 1'b0;
   assign charge_status_pin_o   = 1'b0;
   assign fault_pin_o           = 1'b0;
   assign charge_enable         = (st_q == CSTH_CHARGE) && !hold && active;
   assign trickle_mode          = trickle_q;
   assign temp_hold             = hold;

   // assertions
   a_power_flag_follows: assert property (@(posedge ref_clk) disable iff (srst)
      cmp_in.supply_ok |=> (st_out_q.power_present_flag == csth_pkg::CSTH_OD_STRONG))
      else $error("power flag not driven with supply");

   a_hold_stops_charge: assert property (@(posedge ref_clk) disable iff (srst)
      hold |-> !charge_enable)
      else $error("charge enabled during hold");

   a_timer_frozen: assert property (@(posedge ref_clk) disable iff (srst)
      (hold && !restart && st_q == CSTH_CHARGE) |=> (cnt == $past(cnt)))
      else $error("timer moved during hold");

   a_grounded_no_hold: assert property (@(posedge ref_clk) disable iff (srst)
      (cmp_in.therm_grounded && st_q == CSTH_CHARGE && !trickle_q && !restart)
      |=> (st_out_q.fault_pin == csth_pkg::CSTH_OD_HIZ))
      else $error("hold with grounded thermistor");

   a_hot_holds: assert property (@(posedge ref_clk) disable iff (srst)
      (cmp_in.therm_hot && !cmp_in.therm_grounded && st_q == CSTH_CHARGE && !restart)
      |=> (st_out_q.fault_pin == csth_pkg::CSTH_OD_STRONG))
      else $error("hot did not hold");

   a_shutdown_clears: assert property (@(posedge ref_clk) disable iff (srst)
      cmp_in.current_program_pin_shutdown |=> (cnt == '0) && (st_q == CSTH_IDLE) && !tenth_q)
      else $error("shutdown did not reset");

   a_tenth_weak: assert property (@(posedge ref_clk) disable iff (srst)
      (tenth_q && st_q == CSTH_CHARGE) |=> (st_out_q.charge_status_pin != csth_pkg::CSTH_OD_STRONG))
      else $error("strong pulldown after tenth point");

   sequence s_badcell_entry;
      (st_q == CSTH_CHARGE) ##1 (st_q == CSTH_BADCELL);
   endsequence
   a_badcell_release: assert property (@(posedge ref_clk) disable iff (srst)
      s_badcell_entry |-> (st_out_q.charge_status_pin == csth_pkg::CSTH_OD_HIZ)
                          && (st_out_q.fault_pin == csth_pkg::CSTH_OD_STRONG))
      else $error("bad cell outputs not simultaneous");

   a_done_released: assert property (@(posedge ref_clk) disable iff (srst)
      (st_q == CSTH_DONE) |-> (st_out_q.charge_status_pin == csth_pkg::CSTH_OD_HIZ))
      else $error("status pin driven after timeout");
endmodule
`default_nettype wire

//--- sim/csth_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side: charge status line read through a small or a large pull-up
module csth_host_model (
   input  wire logic drive_hi,
   input  wire logic strong_pd,
   input  wire logic weak_pd,
   output logic      line_level
);
   // strong pulldown wins even against the small pull-up
   // weak pulldown only wins against the large pull-up
   always_comb begin
      if (strong_pd) begin
         line_level = 1'b0;
      end else if (weak_pd && !drive_hi) begin
         line_level = 1'b0;
      end else begin
         line_level = 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [1:0] od_z = csth_pkg::CSTH_OD_HIZ;
   localparam logic [1:0] od_s = csth_pkg::CSTH_OD_STRONG;
   localparam logic [1:0] od_w = csth_pkg::CSTH_OD_WEAK;
   typedef struct packed {
      logic [6:0] cmp;
      logic [5:0] st;
      logic       en;
      logic       chk;
   } csth_row_t;
   logic                   ref_clk;
   logic                   srst;
   logic                   timer_tick;
   logic                   drive_hi;
   logic                   line_level;
   logic [2:0]             oe;
   logic                   charge_enable;
   logic                   trickle_mode;
   logic                   temp_hold;
   logic [2:0]             od_o;
   csth_pkg::csth_cmp_t    cmp_in;
   csth_pkg::csth_status_t status_out;
   csth_row_t              rows [10];
   int                     n_fail;
   int                     total_checks;
   int                     k;

   csth_status #(.TIMER_W(24)) uut (
      .ref_clk(ref_clk), .srst(srst), .cmp_in(cmp_in), .timer_tick(timer_tick),
      .timer_term(24'h000010), .status_out(status_out),
      .power_present_flag_oe(oe[2]), .charge_status_pin_oe(oe[1]), .fault_pin_oe(oe[0]),
      .power_present_flag_o(od_o[2]), .charge_status_pin_o(od_o[1]), .fault_pin_o(od_o[0]),
      .charge_enable(charge_enable), .trickle_mode(trickle_mode), .temp_hold(temp_hold)
   );
   csth_host_model host (.drive_hi(drive_hi), .strong_pd(oe[1]),
      .weak_pd(status_out.charge_status_pin == od_w), .line_level(line_level));

   task automatic chk(input string name, input logic [5:0] seen, input logic [5:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apply(input logic [6:0] c);
      cmp_in = c;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         timer_tick = 1'b1;
         @(negedge ref_clk);
         timer_tick = 1'b0;
         @(negedge ref_clk);
      end
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      srst = 1'b1;
      cmp_in = '0;
      timer_tick = 1'b0;
      drive_hi = 1'b0;
      rows = '{'{7'h00, {od_z, od_z, od_z}, 1'b0, 1'b1},
               '{7'h40, {od_s, od_s, od_z}, 1'b1, 1'b1},
               '{7'h48, {od_s, od_s, od_s}, 1'b0, 1'b1},
               '{7'h44, {od_s, od_s, od_s}, 1'b0, 1'b1},
               '{7'h4A, {od_s, od_s, od_z}, 1'b1, 1'b1},
               '{7'h50, {od_s, od_w, od_z}, 1'b1, 1'b1},
               '{7'h58, {od_s, od_w, od_s}, 1'b0, 1'b1},
               '{7'h40, {od_s, od_w, od_z}, 1'b1, 1'b1},
               '{7'h41, {od_s, od_z, od_z}, 1'b0, 1'b1},
               '{7'h40, {od_s, od_s, od_z}, 1'b1, 1'b1}};
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      foreach (rows[i]) begin
         apply(rows[i].cmp);
         if (rows[i].chk) begin
            chk("status", status_out, rows[i].st);
            chk("enable", charge_enable, rows[i].en);
            chk("hold", temp_hold, (rows[i].cmp[3] || rows[i].cmp[2])
               && !rows[i].cmp[1]);
            chk("oe", oe, {rows[i].st[5:4] == od_s, rows[i].st[3:2] == od_s,
               rows[i].st[1:0] == od_s});
            for (int d = 0; d < 2; d++) begin
               drive_hi = d[0];
               #1;
               chk("host", line_level, (rows[i].st[3:2] != od_s) && (d == 1
                  || rows[i].st[3:2] == od_z));
            end
            @(negedge ref_clk);
         end
      end
      chk("od_o", od_o, 3'h0);
      // timer frozen in hold, then runs to the end
      apply(7'h00);
      apply(7'h48);
      ticks(20);
      chk("hold_chg", status_out.charge_status_pin, od_s);
      apply(7'h40);
      ticks(15);
      chk("pre_done", status_out.charge_status_pin, od_s);
      ticks(1);
      repeat (2) @(negedge ref_clk);
      chk("done", status_out, {od_s, od_z, od_z});
      chk("done_en", charge_enable, 1'b0);
      apply(7'h48);
      chk("late_fault", status_out, {od_s, od_z, od_s});
      // bad cell in trickle
      apply(7'h00);
      apply(7'h60);
      chk("trickle", trickle_mode, 1'b1);
      k = 0;
      while (status_out.charge_status_pin != od_z && k < 8) begin
         chk("together", status_out.fault_pin == od_s, 1'b0);
         ticks(1);
         k++;
      end
      if (k == 8) begin
         n_fail++;
      end
      chk("quarter", k == 4, 1'b1);
      chk("bad", status_out, {od_s, od_z, od_s});
      apply(7'h40);
      chk("clear", status_out, {od_s, od_s, od_z});
      ticks(15);
      chk("fresh", status_out.charge_status_pin, od_s);
      // reset in mid-run
      srst = 1'b1;
      @(negedge ref_clk);
      chk("rst", status_out, 6'h00);
      chk("rst_oe", oe, 3'h0);
      srst = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("rst_run", status_out, {od_s, od_s, od_z});
      tally_and_finish();
   end
endmodule
`default_nettype wire
